/* hdl/sfl_defines.svh */
// Purpose: Offsets, field positions and reset values for the status flag block
// Assumes: AXI4-Lite register window, 32-bit data
// Notes:   Definitions only
`ifndef SFL_DEFINES_SVH
`define SFL_DEFINES_SVH
// ****************************************
// Flag field positions
// ****************************************
`define SFL_BIT_SIGN      3'd7
`define SFL_BIT_ZERO      3'd6
`define SFL_BIT_HALF      3'd4
`define SFL_BIT_PV        3'd2
`define SFL_BIT_SUB       3'd1
`define SFL_BIT_CARRY     3'd0
`define SFL_USED_MASK     8'hd7
`define SFL_FLAGS_RESET   8'h00
// ****************************************
// Register offsets
// ****************************************
`define SFL_OFF_FLAGS     8'h00
`define SFL_OFF_ALT       8'h04
`define SFL_OFF_OPERAND   8'h08
`define SFL_OFF_COMMAND   8'h0c
`define SFL_OFF_RESULT    8'h10
`define SFL_OFF_COND      8'h14
// ****************************************
// Command word fields
// ****************************************
`define SFL_CMD_OP_LSB    0
`define SFL_CMD_OP_MSB    4
`define SFL_CMD_BIT_LSB   8
`define SFL_CMD_BIT_MSB   10
`define SFL_CMD_ZCNT_BIT  12
`define SFL_CMD_IEC_BIT   13
`define SFL_CMD_REQ_BIT   31
`endif

/* hdl/sfl_pkg.sv */
// Purpose: Types for the status flag block
// Assumes: Used with sfl_defines.svh
// Notes:   Operation codes are this block's own numbering
package sfl_pkg;
  typedef enum logic [4:0] {
    SFL_OP_NOP        = 5'h00, SFL_OP_ADD        = 5'h01, SFL_OP_ADC        = 5'h02,
    SFL_OP_SUB        = 5'h03, SFL_OP_SBC        = 5'h04, SFL_OP_CMP        = 5'h05,
    SFL_OP_AND        = 5'h06, SFL_OP_OR         = 5'h07, SFL_OP_XOR        = 5'h08,
    SFL_OP_ROTL_CARRY = 5'h09, SFL_OP_ROTR_CARRY = 5'h0a, SFL_OP_CIRCL_ACC  = 5'h0b,
    SFL_OP_CIRCR_ACC  = 5'h0c, SFL_OP_CIRCL_OP   = 5'h0d, SFL_OP_CIRCR_OP   = 5'h0e,
    SFL_OP_ARITH_LSH  = 5'h0f, SFL_OP_ARITH_RSH  = 5'h10, SFL_OP_LOGIC_RSH  = 5'h11,
    SFL_OP_DEC_ADJ    = 5'h12, SFL_OP_CARRY_SET  = 5'h13, SFL_OP_CARRY_INV  = 5'h14,
    SFL_OP_SEARCH     = 5'h15, SFL_OP_COPY       = 5'h16, SFL_OP_PORTIO     = 5'h17,
    SFL_OP_BITTEST    = 5'h18, SFL_OP_INC        = 5'h19, SFL_OP_ACC_LOAD   = 5'h1a,
    SFL_OP_EXCH       = 5'h1b
  } sfl_op_t;
  typedef enum logic [1:0] {
    SFL_RD_IDLE = 2'b00,
    SFL_RD_RESP = 2'b01
  } sfl_rd_state_t;
endpackage

/* hdl/sfl_status_flags.sv */
// Purpose: Status flag byte, its alternate copy, and the flag arithmetic behind it
// Assumes: One clock aclk at 20 MHz; synchronous active-low reset; AXI4-Lite slave
// Notes:   Software writes operands then a command with bit 31 set; flags update the next edge
// How it works
// - Main and alternate flag bytes are kept, six meaningful bits each.
// - Sign bit 7, zero 6, half 4, parity/overflow 2, subtract 1, carry 0.
// - Only carry, parity/overflow, zero and sign feed branch conditions.
// - Add sets carry on carry out; subtract sets carry on borrow.
// - Decimal adjust sets carry when the upper-digit correction condition holds.
// - Rotate-through-carry on accumulator links carry between byte ends.
// - Circular left rotates and arithmetic left shift load carry from bit 7.
// - Circular right rotates and right shifts load carry from bit 0.
// - AND, OR and XOR always clear carry.
// - Set-carry forces carry high; invert-carry complements it.
// - Subtract flag is 0 for additions, 1 for subtractions.
// - Arithmetic parity/overflow flags signed results outside -128 to +127.
// - Overflow is carry into sign bit XOR carry out of it.
// - Logical results and operand rotates and shifts give parity: 1 for even ones count.
// - Search and copy clear parity/overflow when counter reaches zero.
// - Loads from vector base or refresh counter copy interrupt enable copy.
// - Port input sets parity, zero and sign from the input byte.
// - Half carry marks carry from bit 3 or borrow from bit 4.
// - Zero flag is set when the eight-bit result is zero.
// - Compare sets zero when accumulator equals the pointed memory byte.
// - Bit test loads zero with the inverse of the chosen bit.
// - Block port steps set zero when decremented B reaches zero.
// - Sign copies bit 7 of the result.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`include "sfl_defines.svh"

module sfl_status_flags
  import sfl_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [7:0]       flags_out,
  output logic [3:0]       cond_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic even_parity(input logic [7:0] v);
    even_parity = ~^v;
  endfunction

  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [4:0] lo;
    logic [7:0] lo7;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    lo7  = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
    full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    // Packed as [9] half carry, [8] signed overflow, [7:0] sum byte
    add8 = {lo[4], lo7[7] ^ full[8], full[7:0]};
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  flags_reg;
  logic [7:0]  alt_reg;
  logic [15:0] operand_reg;
  logic [7:0]  result_reg;
  logic [7:0]  flags_next;
  logic [7:0]  result_next;
  logic        cmd_go;
  logic [31:0] cmd_word;

  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;

  // ****************************************
  // Write channel
  // ****************************************
  // Address and data are caught separately so the master may offer them in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == `SFL_OFF_FLAGS || aw_addr_reg == `SFL_OFF_ALT ||
            aw_addr_reg == `SFL_OFF_OPERAND || aw_addr_reg == `SFL_OFF_COMMAND) begin
          s_axi_bresp <= 2'b00;
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_fire;
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign cmd_word = w_data_reg;
  assign cmd_go   = wr_fire && aw_addr_reg == `SFL_OFF_COMMAND && w_strb_reg[3] &&
                    cmd_word[`SFL_CMD_REQ_BIT];

  // ****************************************
  // Flag computation
  // ****************************************
  sfl_op_t    op;
  logic [2:0] bit_sel;
  logic [7:0] acc;
  logic [7:0] opb;
  logic [9:0] sum;
  logic       hc;
  logic [7:0] dcor;
  logic [8:0] cy;

  assign op      = sfl_op_t'(cmd_word[`SFL_CMD_OP_MSB:`SFL_CMD_OP_LSB]);
  assign bit_sel = cmd_word[`SFL_CMD_BIT_MSB:`SFL_CMD_BIT_LSB];
  assign acc     = operand_reg[7:0];
  assign opb     = operand_reg[15:8];

  always_comb begin
    flags_next  = flags_reg;
    result_next = result_reg;
    sum         = 10'h000;
    hc          = 1'b0;
    dcor        = 8'h00;
    cy          = 9'h000;
    case (op)
      SFL_OP_ADD, SFL_OP_ADC: begin
        sum = add8(acc, opb, op == SFL_OP_ADC && flags_reg[`SFL_BIT_CARRY]);
        result_next = sum[7:0];
        cy = {1'b0, acc} + {1'b0, opb} + {8'h00, op == SFL_OP_ADC && flags_reg[`SFL_BIT_CARRY]};
        flags_next[`SFL_BIT_CARRY] = cy[8];
        flags_next[`SFL_BIT_HALF] = sum[9];
        flags_next[`SFL_BIT_PV]   = sum[8];
        flags_next[`SFL_BIT_SUB]  = 1'b0;
        flags_next[`SFL_BIT_ZERO] = result_next == 8'h00;
        flags_next[`SFL_BIT_SIGN] = result_next[7];
      end
      SFL_OP_SUB, SFL_OP_SBC, SFL_OP_CMP: begin
        // Subtraction as a + ~b + 1; borrow is the inverse of the carries
        sum = add8(acc, ~opb, !(op == SFL_OP_SBC && flags_reg[`SFL_BIT_CARRY]));
        result_next = acc - opb - {7'h00, op == SFL_OP_SBC && flags_reg[`SFL_BIT_CARRY]};
        cy = {1'b0, acc} - {1'b0, opb} - {8'h00, op == SFL_OP_SBC && flags_reg[`SFL_BIT_CARRY]};
        flags_next[`SFL_BIT_CARRY] = cy[8];
        flags_next[`SFL_BIT_HALF] = !sum[9];
        flags_next[`SFL_BIT_PV]   = sum[8];
        flags_next[`SFL_BIT_SUB]  = 1'b1;
        flags_next[`SFL_BIT_ZERO] = result_next == 8'h00;
        flags_next[`SFL_BIT_SIGN] = result_next[7];
        if (op == SFL_OP_CMP) begin
          result_next = result_reg;
        end
      end
      SFL_OP_AND, SFL_OP_OR, SFL_OP_XOR: begin
        if (op == SFL_OP_AND) begin
          result_next = acc & opb;
        end else if (op == SFL_OP_OR) begin
          result_next = acc | opb;
        end else begin
          result_next = acc ^ opb;
        end
        flags_next[`SFL_BIT_CARRY] = 1'b0;
        flags_next[`SFL_BIT_PV]    = even_parity(result_next);
        flags_next[`SFL_BIT_HALF]  = op == SFL_OP_AND;
        flags_next[`SFL_BIT_SUB]   = 1'b0;
        flags_next[`SFL_BIT_ZERO]  = result_next == 8'h00;
        flags_next[`SFL_BIT_SIGN]  = result_next[7];
      end
      SFL_OP_ROTL_CARRY, SFL_OP_ROTR_CARRY, SFL_OP_CIRCL_ACC, SFL_OP_CIRCR_ACC: begin
        // Accumulator rotates touch only carry, half and subtract
        if (op == SFL_OP_ROTL_CARRY) begin
          result_next = {acc[6:0], flags_reg[`SFL_BIT_CARRY]};
          flags_next[`SFL_BIT_CARRY] = acc[7];
        end else if (op == SFL_OP_ROTR_CARRY) begin
          result_next = {flags_reg[`SFL_BIT_CARRY], acc[7:1]};
          flags_next[`SFL_BIT_CARRY] = acc[0];
        end else if (op == SFL_OP_CIRCL_ACC) begin
          result_next = {acc[6:0], acc[7]};
          flags_next[`SFL_BIT_CARRY] = acc[7];
        end else begin
          result_next = {acc[0], acc[7:1]};
          flags_next[`SFL_BIT_CARRY] = acc[0];
        end
        flags_next[`SFL_BIT_HALF] = 1'b0;
        flags_next[`SFL_BIT_SUB]  = 1'b0;
      end
      SFL_OP_CIRCL_OP, SFL_OP_CIRCR_OP, SFL_OP_ARITH_LSH, SFL_OP_ARITH_RSH, SFL_OP_LOGIC_RSH: begin
        if (op == SFL_OP_CIRCL_OP) begin
          result_next = {acc[6:0], acc[7]};
        end else if (op == SFL_OP_ARITH_LSH) begin
          result_next = {acc[6:0], 1'b0};
        end else if (op == SFL_OP_CIRCR_OP) begin
          result_next = {acc[0], acc[7:1]};
        end else if (op == SFL_OP_ARITH_RSH) begin
          result_next = {acc[7], acc[7:1]};
        end else begin
          result_next = {1'b0, acc[7:1]};
        end
        if (op == SFL_OP_CIRCL_OP || op == SFL_OP_ARITH_LSH) begin
          flags_next[`SFL_BIT_CARRY] = acc[7];
        end else begin
          flags_next[`SFL_BIT_CARRY] = acc[0];
        end
        flags_next[`SFL_BIT_PV]   = even_parity(result_next);
        flags_next[`SFL_BIT_HALF] = 1'b0;
        flags_next[`SFL_BIT_SUB]  = 1'b0;
        flags_next[`SFL_BIT_ZERO] = result_next == 8'h00;
        flags_next[`SFL_BIT_SIGN] = result_next[7];
      end
      SFL_OP_DEC_ADJ: begin
        hc = flags_reg[`SFL_BIT_HALF] || acc[3:0] > 4'h9;
        if (hc) begin
          dcor[3:0] = 4'h6;
        end
        if (flags_reg[`SFL_BIT_CARRY] || acc > 8'h99) begin
          dcor[7:4] = 4'h6;
          flags_next[`SFL_BIT_CARRY] = 1'b1;
        end
        if (flags_reg[`SFL_BIT_SUB]) begin
          result_next = acc - dcor;
          flags_next[`SFL_BIT_HALF] = flags_reg[`SFL_BIT_HALF] && acc[3:0] < 4'h6;
        end else begin
          result_next = acc + dcor;
          flags_next[`SFL_BIT_HALF] = acc[3:0] > 4'h9;
        end
        flags_next[`SFL_BIT_PV]   = even_parity(result_next);
        flags_next[`SFL_BIT_ZERO] = result_next == 8'h00;
        flags_next[`SFL_BIT_SIGN] = result_next[7];
      end
      SFL_OP_CARRY_SET: begin
        flags_next[`SFL_BIT_CARRY] = 1'b1;
        flags_next[`SFL_BIT_HALF]  = 1'b0;
        flags_next[`SFL_BIT_SUB]   = 1'b0;
      end
      SFL_OP_CARRY_INV: begin
        flags_next[`SFL_BIT_CARRY] = !flags_reg[`SFL_BIT_CARRY];
        flags_next[`SFL_BIT_HALF]  = flags_reg[`SFL_BIT_CARRY];
        flags_next[`SFL_BIT_SUB]   = 1'b0;
      end
      SFL_OP_SEARCH: begin
        flags_next[`SFL_BIT_ZERO] = acc == opb;
        flags_next[`SFL_BIT_SIGN] = 8'(acc - opb) >> 7 != 8'h00;
        flags_next[`SFL_BIT_PV]   = !cmd_word[`SFL_CMD_ZCNT_BIT];
        flags_next[`SFL_BIT_SUB]  = 1'b1;
      end
      SFL_OP_COPY: begin
        flags_next[`SFL_BIT_PV]   = !cmd_word[`SFL_CMD_ZCNT_BIT];
        flags_next[`SFL_BIT_HALF] = 1'b0;
        flags_next[`SFL_BIT_SUB]  = 1'b0;
      end
      SFL_OP_PORTIO: begin
        flags_next[`SFL_BIT_ZERO] = acc == 8'h01;
        flags_next[`SFL_BIT_SUB]  = 1'b1;
        result_next = acc - 8'h01;
      end
      SFL_OP_BITTEST: begin
        flags_next[`SFL_BIT_ZERO] = !acc[bit_sel];
        flags_next[`SFL_BIT_HALF] = 1'b1;
        flags_next[`SFL_BIT_SUB]  = 1'b0;
      end
      SFL_OP_INC: begin
        // Port input into a register
        result_next = acc;
        flags_next[`SFL_BIT_PV]   = even_parity(acc);
        flags_next[`SFL_BIT_ZERO] = acc == 8'h00;
        flags_next[`SFL_BIT_SIGN] = acc[7];
        flags_next[`SFL_BIT_HALF] = 1'b0;
        flags_next[`SFL_BIT_SUB]  = 1'b0;
      end
      SFL_OP_ACC_LOAD: begin
        // Accumulator load from vector base or refresh counter
        result_next = acc;
        flags_next[`SFL_BIT_PV]   = cmd_word[`SFL_CMD_IEC_BIT];
        flags_next[`SFL_BIT_ZERO] = acc == 8'h00;
        flags_next[`SFL_BIT_SIGN] = acc[7];
        flags_next[`SFL_BIT_HALF] = 1'b0;
        flags_next[`SFL_BIT_SUB]  = 1'b0;
      end
      default: begin
        flags_next = flags_reg;
      end
    endcase
    flags_next = flags_next & `SFL_USED_MASK;
  end

  // ****************************************
  // Flag storage
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg  <= `SFL_FLAGS_RESET;
      alt_reg    <= `SFL_FLAGS_RESET;
      result_reg <= 8'h00;
    end else if (cmd_go && op == SFL_OP_EXCH) begin
      flags_reg <= alt_reg;
      alt_reg   <= flags_reg;
    end else if (cmd_go) begin
      flags_reg  <= flags_next;
      result_reg <= result_next;
    end else if (wr_fire && aw_addr_reg == `SFL_OFF_FLAGS && w_strb_reg[0]) begin
      flags_reg <= w_data_reg[7:0] & `SFL_USED_MASK;
    end else if (wr_fire && aw_addr_reg == `SFL_OFF_ALT && w_strb_reg[0]) begin
      alt_reg <= w_data_reg[7:0] & `SFL_USED_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operand_reg <= 16'h0000;
    end else if (wr_fire && aw_addr_reg == `SFL_OFF_OPERAND) begin
      if (w_strb_reg[0]) begin
        operand_reg[7:0] <= w_data_reg[7:0];
      end
      if (w_strb_reg[1]) begin
        operand_reg[15:8] <= w_data_reg[15:8];
      end
    end
  end

  // Outputs come from flip-flops one edge after the flag byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_out <= 8'h00;
      cond_out  <= 4'h0;
    end else begin
      flags_out <= flags_reg;
      cond_out  <= {flags_reg[`SFL_BIT_SIGN], flags_reg[`SFL_BIT_ZERO],
                    flags_reg[`SFL_BIT_PV], flags_reg[`SFL_BIT_CARRY]};
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  sfl_rd_state_t rd_state;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state      <= SFL_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      case (rd_state)
        SFL_RD_IDLE: begin
          s_axi_arready <= s_axi_arvalid && !s_axi_arready;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            rd_state      <= SFL_RD_RESP;
            s_axi_rresp   <= 2'b00;
            if (s_axi_araddr == `SFL_OFF_FLAGS) begin
              s_axi_rdata <= {24'h000000, flags_reg};
            end else if (s_axi_araddr == `SFL_OFF_ALT) begin
              s_axi_rdata <= {24'h000000, alt_reg};
            end else if (s_axi_araddr == `SFL_OFF_OPERAND) begin
              s_axi_rdata <= {16'h0000, operand_reg};
            end else if (s_axi_araddr == `SFL_OFF_COMMAND) begin
              s_axi_rdata <= 32'h0000_0000;
            end else if (s_axi_araddr == `SFL_OFF_RESULT) begin
              s_axi_rdata <= {24'h000000, result_reg};
            end else if (s_axi_araddr == `SFL_OFF_COND) begin
              s_axi_rdata <= {28'h0000000, flags_reg[`SFL_BIT_SIGN], flags_reg[`SFL_BIT_ZERO],
                              flags_reg[`SFL_BIT_PV], flags_reg[`SFL_BIT_CARRY]};
            end else begin
              s_axi_rdata <= 32'h0000_0000;
              s_axi_rresp <= 2'b10;
            end
          end
        end
        SFL_RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state     <= SFL_RD_IDLE;
          end
        end
        default: begin
          rd_state <= SFL_RD_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_unused_bits_zero: assert property (flags_reg[5] == 1'b0 && flags_reg[3] == 1'b0)
    else $error("unused flag bits set");
  chk_logic_clears_carry: assert property ((cmd_go && (op == SFL_OP_AND || op == SFL_OP_OR || op == SFL_OP_XOR))
    |=> !flags_reg[`SFL_BIT_CARRY]) else $error("logic op left carry set");
  chk_set_carry_op: assert property ((cmd_go && op == SFL_OP_CARRY_SET) |=> flags_reg[`SFL_BIT_CARRY])
    else $error("set carry failed");
  chk_carry_inverts: assert property ((cmd_go && op == SFL_OP_CARRY_INV)
    |=> flags_reg[`SFL_BIT_CARRY] != $past(flags_reg[`SFL_BIT_CARRY])) else $error("carry not inverted");
  chk_sub_flag_set: assert property ((cmd_go && op == SFL_OP_SUB) |=> flags_reg[`SFL_BIT_SUB])
    else $error("subtract flag not set");
  chk_add_flag_clr: assert property ((cmd_go && op == SFL_OP_ADD) |=> !flags_reg[`SFL_BIT_SUB])
    else $error("subtract flag not cleared");
  chk_bit_test_zero: assert property ((cmd_go && op == SFL_OP_BITTEST)
    |=> flags_reg[`SFL_BIT_ZERO] == !$past(acc[bit_sel])) else $error("bit test zero wrong");
  chk_idle_keeps: assert property ((!cmd_go && !wr_fire) |=> flags_reg == $past(flags_reg))
    else $error("flags changed without command");
  chk_cond_follow: assert property (##1 cond_out[0] == $past(flags_reg[`SFL_BIT_CARRY]))
    else $error("condition output lags wrong");

endmodule // sfl_status_flags

/* bench/sfl_status_flags_tb.sv */
// Purpose: Self-checking bench for the status flag block
// Assumes: 50 ns clock, AXI4-Lite master tasks, op codes from sfl_pkg
// Notes:   Flags are masked to the bits each op defines, so undefined bits never fail a test
module sfl_status_flags_tb
  import sfl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, flags_out, a, b, f, e;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
  logic [3:0]  s_axi_wstrb, cond_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
  int          mismatches, n_tests, cyc;
  sfl_op_t     ro[9] = '{SFL_OP_CIRCL_ACC, SFL_OP_CIRCL_OP, SFL_OP_ARITH_LSH, SFL_OP_ROTL_CARRY, SFL_OP_CIRCR_ACC,
                         SFL_OP_CIRCR_OP, SFL_OP_ARITH_RSH, SFL_OP_LOGIC_RSH, SFL_OP_ROTR_CARRY};
  sfl_op_t     lo[3] = '{SFL_OP_AND, SFL_OP_OR, SFL_OP_XOR};
  logic [15:0] cn[4] = '{16'h7869, 16'h7fc0, 16'h0000, 16'hff01};
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin mismatches++; $display("Error t=%0t got %h exp %h", $time, g, x); end end
  sfl_status_flags uut (.*);
  // ****************************************
  // Clock, timeout, master tasks
  // ****************************************
  always #25 aclk = ~aclk;
  // Ceiling far above the few thousand cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_val = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic op(input logic [7:0] x, input logic [7:0] y, input logic [31:0] cmd);
    wr(8'h08, {16'h0000, y, x});
    wr(8'h0c, cmd | 32'h8000_0000);
    rd(8'h00);
    f = rd_val[7:0];
  endtask
  function automatic logic [7:0] ex_arith(input logic [7:0] x, input logic [7:0] y, input logic s, input logic c);
    logic [8:0] r;
    logic [4:0] h;
    r = s ? {1'b0, x} - {1'b0, y} - {8'h00, c} : {1'b0, x} + {1'b0, y} + {8'h00, c};
    h = s ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, c} : {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, c};
    return {r[7], r[7:0] == 8'h00, 1'b0, h[4], 1'b0, (x[7] ^ s) == y[7] && r[7] != x[7], s, r[8]};
  endfunction
  function automatic logic [7:0] ex_logic(input logic [7:0] r);
    return {r[7], r == 8'h00, 3'b000, ~^r, 2'b00};
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(48));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00); `CHK(rd_val[7:0], 8'h00)
    `CHK(rr, 2'b00)
    rd(8'h04); `CHK(rd_val[7:0], 8'h00)
    // Corner pairs cover positive overflow on add and on subtract and zero results before random pairs
    for (int i = 0; i < 24; i++) begin
      {a, b} = i < 4 ? cn[i] : 16'($urandom);
      op(a, b, SFL_OP_ADD); `CHK(f & 8'hd7, ex_arith(a, b, 1'b0, 1'b0))
      e = ex_arith(a, b, 1'b1, 1'b0);
      op(a, b, SFL_OP_SUB); `CHK(f & 8'hd7, e)
      `CHK(flags_out & 8'hd7, e)
      `CHK(cond_out, {e[7], e[6], e[2], e[0]})
      rd(8'h14); `CHK(rd_val[3:0], {e[7], e[6], e[2], e[0]})
      rd(8'h10); `CHK(rd_val[7:0], 8'(a - b))
      e = ex_arith(a, b, 1'b0, e[0]);
      op(a, b, SFL_OP_ADC); `CHK(f & 8'hd7, e)
      e = ex_arith(a, b, 1'b1, e[0]);
      op(a, b, SFL_OP_SBC); `CHK(f & 8'hd7, e)
      op(a, b, SFL_OP_CMP); `CHK(f & 8'hd7, ex_arith(a, b, 1'b1, 1'b0))
      for (int k = 0; k < 3; k++) begin
        wr(8'h00, 32'h01);
        op(a, b, lo[k]); `CHK(f & 8'hc5, ex_logic(k == 0 ? a & b : k == 1 ? a | b : a ^ b))
      end
      for (int k = 0; k < 9; k++) begin
        op(a, a, ro[k]); `CHK(f[0], k < 4 ? a[7] : a[0])
      end
      op(a, a, SFL_OP_BITTEST | (i % 8) << 8); `CHK(f[6], ~a[i % 8])
      op(a, a, SFL_OP_INC); `CHK(f & 8'hc4, ex_logic(a) & 8'hc4)
    end
    wr(8'h00, 32'hc4);
    op(8'h00, 8'h00, SFL_OP_CARRY_SET); `CHK(f & 8'hc5, 8'hc5)
    op(8'h00, 8'h00, SFL_OP_CARRY_INV); `CHK(f & 8'hc5, 8'hc4)
    wr(8'h00, 32'h00);
    op(8'h9a, 8'h00, SFL_OP_DEC_ADJ); `CHK(f & 8'h41, 8'h41)
    wr(8'h00, 32'h00);
    op(8'h12, 8'h00, SFL_OP_DEC_ADJ); `CHK(f[0], 1'b0)
    for (int j = 0; j < 2; j++) begin
      op(a, a, SFL_OP_SEARCH | j << 12); `CHK(f[2], ~j[0])
      op(a, a, SFL_OP_COPY | j << 12); `CHK(f[2], ~j[0])
      op(a, a, SFL_OP_ACC_LOAD | j << 13); `CHK(f[2], j[0])
      op(8'(j + 1), 8'h00, SFL_OP_PORTIO); `CHK(f[6], j == 0)
    end
    wr(8'h00, 32'h41);
    wr(8'h04, 32'h80);
    wr(8'h0c, 32'h8000_0000 | SFL_OP_EXCH); `CHK(br, 2'b00)
    rd(8'h00); `CHK(rd_val[7:0], 8'h80)
    rd(8'h04); `CHK(rd_val[7:0], 8'h41)
    rd(8'h20); `CHK(rr, 2'b10)
    wr(8'h20, 32'h00); `CHK(br, 2'b10)
    finish_test();
  end
endmodule // sfl_status_flags_tb
